// >>> hdl/clk_rst_hs_pkg.sv
// shared types and constants for the clock, reset and hot-swap block
package clk_rst_hs_pkg;

  localparam int unsigned CLOCK_HZ          = 10_000_000;
  localparam int unsigned DETECT_PERIOD_US  = 500;
  localparam int unsigned DETECT_PERIOD_CYC =
    (DETECT_PERIOD_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned DETECT_FLOAT_CYC  = 8;
  localparam int unsigned CLOCK_OUT_COUNT   = 4;

  // configuration byte that steers the downstream clock-run pin
  localparam logic [7:0] CLKRUN_CFG_OFFSET  = 8'h6f;
  localparam int unsigned CLKRUN_CFG_BIT    = 4;
  // bridge control register holding the chip reset bit
  localparam logic [7:0] BRIDGE_CTRL_OFFSET = 8'h3c;

  localparam logic [31:0] AD_RESET_VALUE    = 32'h0000_0000;
  localparam logic [3:0]  CBE_RESET_VALUE   = 4'h0;
  localparam logic        PAR_RESET_VALUE   = 1'b0;

  typedef enum logic [1:0] {
    LED_DRIVE,
    LED_FLOAT,
    LED_SAMPLE
  } led_phase_t;

  // downstream bus lines as seen from the forwarding datapath
  typedef struct packed {
    logic [31:0] ad;
    logic [3:0]  downstream_cmd_byte_en;
    logic        downstream_parity;
    logic        ad_oe;
    logic        ctrl_oe;
  } downstream_bus_t;

  typedef struct packed {
    logic        sync_rst_a;
    logic        sync_rst_b;
    led_phase_t  led_phase;
    logic [12:0] period_count;
    logic [3:0]  float_count;
    logic        detect_level;
    logic        detect_valid;
  } state_t;

endpackage

// >>> hdl/clk_rst_hotswap.sv
// clock fan-out, reset propagation and hot-swap pin logic of the bridge
//
// How it works
// - four downstream clock outputs follow the primary clock in phase.
// - upstream timing is taken entirely from the primary clock input.
// - an upstream clock-run pin held low means the clock never stops.
// - downstream clock-run follows upstream state or config bit 4 of 6Fh.
// - upstream reset floats every upstream output without a clock edge.
// - downstream reset is asserted while upstream reset is asserted.
// - downstream reset is also held while the chip reset bit is set.
// - under downstream reset controls float and address/data lines are 0.
// - hot-swap status output flags an insertion or pending extraction.
// - the indicator pin drives the LED showing insertion or removal state.
// - every 500 us the indicator pin floats eight cycles and is sampled.
// - with scan test mode high the scan control pin drives a 0.
`timescale 1ns/1ps

module clk_rst_hotswap
  import clk_rst_hs_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = DETECT_PERIOD_CYC,
  parameter int unsigned FLOAT_CYC  = DETECT_FLOAT_CYC
)
(
  input  wire logic                         i_clock,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_upstream_clock_run_pin,
  input  wire logic                         i_clkrun_cfg_bit,
  input  wire logic                         i_chip_reset_bit,
  input  wire logic                         i_downstream_clock_run_pin,
  input  wire logic                         i_board_event,
  input  wire logic                         i_led_on,
  input  wire logic                         i_hot_swap_indicator_pin,
  input  wire logic                         i_scan_test_mode_in,
  input  wire logic                         i_scan_control_pin,
  input  wire clk_rst_hs_pkg::downstream_bus_t i_downstream_bus,
  input  wire logic                         i_upstream_oe,
  output logic [CLOCK_OUT_COUNT-1:0]        o_downstream_clock,
  output logic                              o_upstream_clock_stoppable,
  output logic                              o_downstream_clock_run_pin,
  output logic                              o_downstream_clock_run_oe,
  output logic                              o_upstream_oe,
  output logic                              o_downstream_rst_n,
  output clk_rst_hs_pkg::downstream_bus_t   o_downstream_bus,
  output logic                              o_hot_swap_board_status_out,
  output logic                              o_hot_swap_indicator_pin,
  output logic                              o_hot_swap_indicator_oe,
  output logic                              o_detect_level,
  output logic                              o_detect_valid,
  output logic                              o_scan_control_pin,
  output logic                              o_scan_control_oe,
  output logic                              o_sys_rst_n
);
  import clk_rst_hs_pkg::*;

  localparam logic [12:0] PERIOD_LAST = 13'(PERIOD_CYC - 1);
  localparam logic [3:0]  FLOAT_LAST  = 4'(FLOAT_CYC - 1);

  state_t state;
  state_t next_state;
  logic   rst_n;
  logic   down_rst_active;

  assign rst_n       = state.sync_rst_b;
  assign o_sys_rst_n = rst_n;

  // pure fan-out keeps the outputs edge-aligned with the primary clock
  assign o_downstream_clock = {CLOCK_OUT_COUNT{i_clock}};

  // a low upstream clock-run means the host never stops the clock
  assign o_upstream_clock_stoppable = i_upstream_clock_run_pin;

  // pin is active low: driven low keeps secondary clocks running
  always_comb
  begin
    if (i_clkrun_cfg_bit)
    begin
      o_downstream_clock_run_pin = 1'b0;
      o_downstream_clock_run_oe  = 1'b1;
    end
    else
    begin
      o_downstream_clock_run_pin = i_upstream_clock_run_pin;
      o_downstream_clock_run_oe  = 1'b1;
    end
  end

  // combinational on the raw pin so the float needs no clock edge
  assign o_upstream_oe = i_upstream_oe & i_rst_n;

  // raw reset keeps assertion asynchronous; bit clear is seen at once
  assign down_rst_active = ~i_rst_n | ~rst_n | i_chip_reset_bit;
  assign o_downstream_rst_n = ~down_rst_active;

  always_comb
  begin
    if (down_rst_active)
    begin
      o_downstream_bus.ad                     = AD_RESET_VALUE;
      o_downstream_bus.downstream_cmd_byte_en = CBE_RESET_VALUE;
      o_downstream_bus.downstream_parity      = PAR_RESET_VALUE;
      o_downstream_bus.ad_oe                  = 1'b1;
      o_downstream_bus.ctrl_oe                = 1'b0;
    end
    else
    begin
      o_downstream_bus = i_downstream_bus;
    end
  end

  // active low status pin
  assign o_hot_swap_board_status_out = ~i_board_event;

  // scan test mode is active high; low leaves the scan control pin floating
  always_comb
  begin
    if (i_scan_test_mode_in)
    begin
      o_scan_control_pin = 1'b0;
      o_scan_control_oe  = 1'b1;
    end
    else
    begin
      o_scan_control_pin = 1'b0;
      o_scan_control_oe  = 1'b0;
    end
  end

  // LED shown as a low drive, the usual sink arrangement
  assign o_hot_swap_indicator_pin = ~i_led_on;
  // released in the float phase and while reset is held; the float phase lasts exactly eight cycles
  assign o_hot_swap_indicator_oe  =
    (state.led_phase != LED_FLOAT) & rst_n;
  assign o_detect_level = state.detect_level;
  assign o_detect_valid = state.detect_valid;

  always_comb
  begin
    next_state              = state;
    next_state.sync_rst_a   = 1'b1;
    next_state.sync_rst_b   = state.sync_rst_a;
    next_state.detect_valid = 1'b0;
    unique case (state.led_phase)
      LED_DRIVE:
      begin
        if (state.period_count == PERIOD_LAST)
        begin
          next_state.period_count = '0;
          next_state.float_count  = '0;
          next_state.led_phase    = LED_FLOAT;
        end
        else
        begin
          next_state.period_count = state.period_count + 13'h1;
        end
      end
      LED_FLOAT:
      begin
        next_state.period_count = state.period_count + 13'h1;
        // sample at the last float cycle, after the pin has settled
        if (state.float_count == FLOAT_LAST)
        begin
          next_state.detect_level = i_hot_swap_indicator_pin;
          next_state.detect_valid = 1'b1;
          next_state.led_phase    = LED_SAMPLE;
        end
        else
        begin
          next_state.float_count = state.float_count + 4'h1;
        end
      end
      LED_SAMPLE:
      begin
        next_state.period_count = state.period_count + 13'h1;
        // pin is driven again here while the fresh level is announced
        next_state.led_phase    = LED_DRIVE;
      end
    endcase
    if (!rst_n)
    begin
      next_state.led_phase    = LED_DRIVE;
      next_state.period_count = '0;
      next_state.float_count  = '0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= '{default: '0, led_phase: LED_DRIVE};
    end
    else
    begin
      state <= next_state;
    end
  end

endmodule

// >>> bench/clk_rst_hs_assertions.sv
// assertions on the ports of the clock, reset and hot-swap block
`timescale 1ns/1ps
module clk_rst_hs_assertions
  import clk_rst_hs_pkg::*;
(
  input wire logic                            i_clock,
  input wire logic                            i_rst_n,
  input wire logic                            i_chip_reset_bit,
  input wire logic                            i_clkrun_cfg_bit,
  input wire logic                            i_board_event,
  input wire logic                            i_scan_test_mode_in,
  input wire logic                            o_downstream_rst_n,
  input wire clk_rst_hs_pkg::downstream_bus_t o_downstream_bus,
  input wire logic                            o_downstream_clock_run_pin,
  input wire logic                            o_downstream_clock_run_oe,
  input wire logic                            o_hot_swap_board_status_out,
  input wire logic                            o_hot_swap_indicator_oe,
  input wire logic                            o_detect_valid,
  input wire logic                            o_scan_control_pin,
  input wire logic                            o_scan_control_oe,
  input wire logic                            o_sys_rst_n
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // float window, then the pin is driven again
  sequence float_s;
    !o_hot_swap_indicator_oe [*8] ##1 o_hot_swap_indicator_oe;
  endsequence
  chip_reset_a: assert property (
    i_chip_reset_bit |-> !o_downstream_rst_n)
    else $error("chip reset bit did not hold downstream reset");
  rst_release_a: assert property (o_sys_rst_n && !i_chip_reset_bit
    |-> o_downstream_rst_n) else $error("downstream reset not released");
  bus_zero_a: assert property (!o_downstream_rst_n |->
    o_downstream_bus == {32'h0, 4'h0, 3'b010}) else $error("bus not parked");
  clkrun_cfg_a: assert property (i_clkrun_cfg_bit |->
    !o_downstream_clock_run_pin && o_downstream_clock_run_oe)
    else $error("clock run not forced low");
  status_out_a: assert property (
    o_hot_swap_board_status_out != i_board_event)
    else $error("status output wrong");
  scan_drive_a: assert property (i_scan_test_mode_in |->
    o_scan_control_oe && !o_scan_control_pin) else $error("scan pin not 0");
  float_len_a: assert property (
    $fell(o_hot_swap_indicator_oe) |-> float_s)
    else $error("indicator float length wrong");
  detect_pulse_a: assert property (
    o_detect_valid |-> o_hot_swap_indicator_oe
    && !$past(o_hot_swap_indicator_oe) ##1 !o_detect_valid)
    else $error("detect pulse misplaced");
endmodule
bind clk_rst_hotswap clk_rst_hs_assertions i_clk_rst_hs_assertions (.*);

// >>> bench/hs_led_partner.sv
// far-side model of the hot-swap indicator pin and its detect source
`timescale 1ns/1ps
module hs_led_partner (
  input  wire logic i_pin,
  input  wire logic i_oe,
  input  wire logic i_detect,
  output logic      o_level
);
  // a released pin shows the external detect source, not the last drive
  assign o_level = i_oe ? i_pin : i_detect;
endmodule

// >>> bench/clk_rst_hotswap_tb_top.sv
// self-checking bench for the clock, reset and hot-swap block
`timescale 1ns/1ps
module clk_rst_hotswap_tb_top;
  import clk_rst_hs_pkg::*;
  localparam int unsigned PER = 20;
  logic i_clock = 0, i_rst_n = 0, ext = 0, pin, stp, uoe, drst_n, status;
  logic crun, crun_oe, ind, ind_oe, dlev, dval, spin, soe, srst;
  logic [5:0] in = 6'b000001;
  logic [3:0] dclk;
  downstream_bus_t bus_in = {32'ha5a5_5a5a, 4'h5, 3'b111}, bus_out;
  int error_cnt = 0, comparisons = 0, n;
  // inputs {up clkrun, cfg, chip, event, led, scan}
  logic [5:0] row_in [6] = '{6'h01, 6'h20, 6'h31, 6'h09, 6'h05, 6'h03};
  // outputs {rst_n, clkrun, status, ind pin, scan oe, scan pin}
  logic [5:0] row_out [6] = '{6'h2e, 6'h3c, 6'h2e, 6'h0e, 6'h26, 6'h2a};
  always #50 i_clock = ~i_clock;
  clk_rst_hotswap #(.PERIOD_CYC(PER)) i_clk_rst_hotswap (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_upstream_clock_run_pin(in[5]),
    .i_clkrun_cfg_bit(in[4]), .i_chip_reset_bit(in[3]),
    .i_downstream_clock_run_pin(1'b0), .i_board_event(in[2]),
    .i_led_on(in[1]), .i_hot_swap_indicator_pin(pin),
    .i_scan_test_mode_in(in[0]), .i_scan_control_pin(1'b0),
    .i_downstream_bus(bus_in), .i_upstream_oe(1'b1),
    .o_downstream_clock(dclk), .o_upstream_clock_stoppable(stp),
    .o_downstream_clock_run_pin(crun), .o_downstream_clock_run_oe(crun_oe),
    .o_upstream_oe(uoe), .o_downstream_rst_n(drst_n),
    .o_downstream_bus(bus_out), .o_hot_swap_board_status_out(status),
    .o_hot_swap_indicator_pin(ind), .o_hot_swap_indicator_oe(ind_oe),
    .o_detect_level(dlev), .o_detect_valid(dval),
    .o_scan_control_pin(spin), .o_scan_control_oe(soe), .o_sys_rst_n(srst));
  hs_led_partner i_hs_led_partner (.i_pin(ind), .i_oe(ind_oe),
    .i_detect(ext), .o_level(pin));
  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // bounded wait for the sample pulse, n counts the cycles taken
  task automatic wait_val;
    n = 0;
    while (dval !== 1'b1 && n < 100)
    begin
      @(negedge i_clock);
      n++;
    end
    if (n >= 100)
    begin
      error_cnt++;
      $display("[FAIL] %0t detect pulse never came", $time);
      stop_test;
    end
  endtask
  initial
  begin
    repeat (3) @(negedge i_clock);
    i_rst_n = 1;
    #10 chk(drst_n, 0);
    repeat (3) @(negedge i_clock);
    for (int r = 0; r < 6; r++)
    begin
      in = row_in[r];
      #10 chk({drst_n, crun, status, ind, soe, spin}, row_out[r]);
      chk(bus_out, row_out[r][5] ? bus_in : {32'h0, 4'h0, 3'b010});
      chk({soe, spin}, {in[0], 1'b0});
      chk({dclk, crun_oe, stp}, {4'h0, 1'b1, in[5]});
      @(posedge i_clock);
      #10 chk(dclk, 4'hf);
      @(negedge i_clock);
    end
    $display("table test done");
    wait_val;
    chk({dlev, ind_oe}, 2'b01);
    ext = 1;
    @(negedge i_clock);
    wait_val;
    // one cycle went by before the wait, so a full period reads PER - 1
    chk({dlev, n[7:0]}, {1'b1, 8'(PER - 1)});
    $display("detect test done");
    #20 i_rst_n = 0;
    #10 chk({uoe, drst_n, ind_oe, dval}, 4'h0);
    @(negedge i_clock);
    i_rst_n = 1;
    #10 chk(drst_n, 0);
    repeat (3) @(negedge i_clock);
    chk({drst_n, uoe}, 2'b11);
    $display("reset test done");
    stop_test;
  end
  initial
  begin
    repeat (1000) @(posedge i_clock);
    error_cnt++;
    stop_test;
  end
endmodule
